// >>> bench/tac_host_model.sv
// Host processor model that issues register commands to the block.
`timescale 1ns/1ps
`default_nettype none
module tac_host_model
  import tac_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Register command port
  output tac_req_t req,
  input wire logic regAck,
  input wire logic [15:0] regRdata
);
  initial
  begin
    req = '0;
  end

  // ********
  // Command cycles
  // ********
  // One strobe cycle, then a bounded wait for the acknowledge.
  // Between commands the address and data lines show the inverse of the
  // last value, so that a stale value is never mistaken for a valid one.
  task automatic cmd(input logic wr, input logic [7:0] addr,
    input logic [15:0] data, output logic [15:0] rdata, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(negedge sys_clk);
    req = '{regWrite: wr, regRead: !wr, regAddr: addr, regWdata: data};
    // The acknowledge and read data stand in the cycle after the strobe.
    while (!ok && n < 4)
    begin
      @(negedge sys_clk);
      ok = (regAck === 1'b1);
      n++;
      req = '{regWrite: 1'b0, regRead: 1'b0, regAddr: ~addr,
        regWdata: ~data};
    end
    rdata = regRdata;
  endtask : cmd

  // Ends an extended alert by writing the clear bit low.
  task automatic hostClear(input logic [15:0] cfg, output logic ok);
    logic [15:0] x;
    cmd(1'b1, TAC_OFS_THR_ZERO, cfg & 16'hFFFB, x, ok);
  endtask : hostClear
endmodule : tac_host_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking testbench for the throttle alert configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tac_pkg::*;
;
  logic sys_clk;
  logic sys_rst;
  tac_req_t req;
  logic regAck;
  logic [15:0] regRdata;
  logic [15:0] inputCurrentMa;
  logic [15:0] inputLimitSettingMa;
  logic [15:0] externalLimitPinMa;
  logic [15:0] systemVoltageMv;
  logic singleCell;
  logic adapterPresent;
  logic [6:0] envelopeSelect;
  tac_ext_src_t extSrc;
  logic [15:0] effectiveLimitMa;
  logic batteryMonitorCharge;
  logic overcurrentTrip;
  logic throttleAlertN;
  int failures;
  int numChecks;
  int n;
  int pcts [7] = '{110, 110, 115, 150, 230, 250, 450};
  logic [4:0] codes [7] = '{5'h00, 5'h01, 5'h02, 5'h09, 5'h19, 5'h1A, 5'h1E};
  int dgCyc [4] = '{TAC_CDEG0_CYC, TAC_CDEG1_CYC, 16, 32};
  int pwCyc [4] = '{TAC_PW0_CYC, 8, 48, 24};
  int vMulti [4] = '{5750, 6000, 6250, 6500};
  int vSingle [4] = '{2850, 3100, 3350, 3600};

  tac_throttle_alert_config #(
    .CDEG2_CYC(16), .NDEG0_CYC(8), .NDEG1_CYC(64),
    .PW1_CYC(8), .PW2_CYC(48)
  ) i_tac_throttle_alert_config (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .regAck(regAck),
    .regRdata(regRdata), .inputCurrentMa(inputCurrentMa),
    .inputLimitSettingMa(inputLimitSettingMa),
    .externalLimitPinMa(externalLimitPinMa),
    .systemVoltageMv(systemVoltageMv), .singleCell(singleCell),
    .adapterPresent(adapterPresent), .envelopeSelect(envelopeSelect),
    .extSrc(extSrc), .effectiveLimitMa(effectiveLimitMa),
    .batteryMonitorCharge(batteryMonitorCharge),
    .overcurrentTrip(overcurrentTrip), .throttleAlertN(throttleAlertN)
  );

  tac_host_model i_tac_host_model (
    .sys_clk(sys_clk), .req(req), .regAck(regAck), .regRdata(regRdata)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ********
  // Helpers
  // ********
  function automatic logic [15:0] b16(input logic v);
    return {15'h0000, v};
  endfunction : b16

  task automatic chk(input logic [15:0] got, exp, input string msg);
    numChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] x;
    logic ok;
    i_tac_host_model.cmd(1'b1, a, d, x, ok);
    chk(b16(ok), 16'h0001, "write ack");
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] x;
    logic ok;
    i_tac_host_model.cmd(1'b0, a, 16'h0000, x, ok);
    chk(b16(ok), 16'h0001, "read ack");
    chk(x, e, "read data");
  endtask : rdChk

  task automatic clr(input logic [15:0] cfg);
    logic ok;
    i_tac_host_model.hostClear(cfg, ok);
    chk(b16(ok), 16'h0001, "clear ack");
  endtask : clr

  task automatic waitLvl(input logic lvl, input int lim, output int c);
    c = 0;
    while (throttleAlertN !== lvl && c < lim)
    begin
      @(negedge sys_clk);
      c++;
    end
  endtask : waitLvl

  task automatic quiet(input int cyc);
    logic lo;
    lo = 1'b0;
    repeat (cyc)
    begin
      @(negedge sys_clk);
      if (throttleAlertN !== 1'b1)
        lo = 1'b1;
    end
    chk(b16(lo), 16'h0000, "unexpected alert");
  endtask : quiet

  // Holds the input at the threshold, then one step beyond it.
  task automatic trip(input logic volt, input logic [15:0] v, input int dg);
    int c;
    if (volt)
      systemVoltageMv = v;
    else
      inputCurrentMa = v;
    quiet(dg + 8);
    if (volt)
      systemVoltageMv = v - 16'h0001;
    else
      inputCurrentMa = v + 16'h0001;
    waitLvl(1'b0, dg + 8, c);
    chk(b16(c >= dg && c <= dg + 4), 16'h0001, "trip delay");
    systemVoltageMv = 16'h1F40;
    inputCurrentMa = 16'h0000;
    waitLvl(1'b1, 80, c);
    chk(b16(throttleAlertN), 16'h0001, "release");
  endtask : trip

  task automatic close_out;
    if (failures == 0 && numChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    $display("[FAIL] %0t run did not finish", $time);
    close_out;
  end

  // ********
  // Tests
  // ********
  initial
  begin
    failures = 0;
    numChecks = 0;
    sys_rst = 1'b1;
    inputCurrentMa = 16'h0000;
    inputLimitSettingMa = 16'h03E8;
    externalLimitPinMa = 16'h02BC;
    systemVoltageMv = 16'h1F40;
    singleCell = 1'b0;
    adapterPresent = 1'b1;
    envelopeSelect = 7'h00;
    extSrc = '0;
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk(b16(throttleAlertN), 16'h0001, "alert idle");
    rdChk(TAC_OFS_OPT_TWO, 16'h0080);
    rdChk(TAC_OFS_THR_ZERO, 16'h4B54);
    rdChk(8'h00, 16'h0000);
    chk(effectiveLimitMa, 16'h02BC, "limit");
    chk(b16(batteryMonitorCharge), 16'h0000, "monitor");
    wr(TAC_OFS_OPT_TWO, 16'hFFFF);
    rdChk(TAC_OFS_OPT_TWO, 16'h00C0);
    chk(b16(batteryMonitorCharge), 16'h0001, "monitor");
    wr(TAC_OFS_OPT_TWO, 16'h0040);
    @(negedge sys_clk);
    chk(effectiveLimitMa, 16'h03E8, "limit");
    wr(TAC_OFS_OPT_TWO, 16'h0080);
    externalLimitPinMa = 16'h07D0;
    repeat (2) @(negedge sys_clk);
    chk(effectiveLimitMa, 16'h03E8, "lower limit");
    envelopeSelect = 7'h40;
    for (int i = 0; i < 4; i++)
    begin
      wr(TAC_OFS_THR_ZERO, {11'h25A, i[1:0], 3'b100});
      extSrc.cmpTrig = 1'b1;
      @(negedge sys_clk);
      extSrc.cmpTrig = 1'b0;
      waitLvl(1'b0, 4, n);
      chk(b16(throttleAlertN), 16'h0000, "alert start");
      waitLvl(1'b1, pwCyc[i] + 8, n);
      chk(b16(n >= pwCyc[i] && n <= pwCyc[i] + 3), 16'h0001, "width");
    end
    envelopeSelect = 7'h00;
    extSrc = '1;
    inputCurrentMa = 16'hFFFF;
    quiet(40);
    adapterPresent = 1'b0;
    envelopeSelect = 7'h33;
    quiet(40);
    envelopeSelect = 7'h3B;
    waitLvl(1'b0, 4, n);
    chk(b16(throttleAlertN), 16'h0000, "kept source");
    extSrc = '0;
    inputCurrentMa = 16'h0000;
    adapterPresent = 1'b1;
    envelopeSelect = 7'h40;
    waitLvl(1'b1, 80, n);
    wr(TAC_OFS_THR_ZERO, 16'h4B74);
    extSrc.cmpTrig = 1'b1;
    waitLvl(1'b0, 4, n);
    clr(16'h4B74);
    chk(b16(throttleAlertN), 16'h0000, "clear while active");
    extSrc.cmpTrig = 1'b0;
    repeat (100) @(negedge sys_clk);
    chk(b16(throttleAlertN), 16'h0000, "extended");
    clr(16'h4B74);
    waitLvl(1'b1, 3, n);
    chk(b16(throttleAlertN), 16'h0001, "cleared");
    envelopeSelect = 7'h00;
    for (int b = 0; b < 2; b++)
    begin
      wr(TAC_OFS_THR_ZERO, {5'h09, 2'b10, b[0], 8'h4C});
      inputCurrentMa = b[0] ? 16'h0BB8 : 16'h0753;
      repeat (2) @(negedge sys_clk);
      chk(b16(overcurrentTrip), 16'h0000, "ocp level");
      inputCurrentMa = inputCurrentMa + 16'h0001;
      repeat (2) @(negedge sys_clk);
      chk(b16(overcurrentTrip), 16'h0001, "ocp trip");
    end
    inputCurrentMa = 16'h0000;
    envelopeSelect = 7'h20;
    for (int i = 0; i < 7; i++)
    begin
      wr(TAC_OFS_THR_ZERO, {codes[i], 11'h54C});
      trip(1'b0, 16'(pcts[i] * 10), 16);
    end
    for (int d = 0; d < 4; d++)
    begin
      wr(TAC_OFS_THR_ZERO, {5'h09, d[1:0], 9'h14C});
      trip(1'b0, 16'h05DC, dgCyc[d]);
    end
    wr(TAC_OFS_THR_ZERO, {TAC_CRIT_OOR, 11'h54C});
    inputCurrentMa = 16'hFFFF;
    quiet(40);
    inputCurrentMa = 16'h0000;
    inputLimitSettingMa = 16'h0FA0;
    for (int c = 30; c < 32; c++)
    begin
      wr(TAC_OFS_THR_ZERO, {c[4:0], 11'h54C});
      trip(1'b0, 16'h23F0, 16);
    end
    inputLimitSettingMa = 16'h03E8;
    envelopeSelect = 7'h10;
    wr(TAC_OFS_THR_ZERO, {5'h09, 11'h54C});
    trip(1'b0, 16'h044C, 8);
    wr(TAC_OFS_THR_ZERO, {5'h09, 11'h54E});
    trip(1'b0, 16'h044C, 64);
    envelopeSelect = 7'h04;
    for (int c = 0; c < 4; c++)
    begin
      wr(TAC_OFS_THR_ZERO, {5'h09, 3'b101, c[1:0], 6'h0C});
      singleCell = 1'b0;
      trip(1'b1, 16'(vMulti[c]), TAC_SYSTEM_VOLTAGE_CYC);
      singleCell = 1'b1;
      trip(1'b1, 16'(vSingle[c]), TAC_SYSTEM_VOLTAGE_CYC);
    end
    close_out;
  end
endmodule : tb_top
`default_nettype wire

// >>> src/tac_deglitch.sv
// Deglitch filter: output rises after the input has held high long enough.
`timescale 1ns/1ps
`default_nettype none
module tac_deglitch
  import tac_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Filter
  input wire logic rawIn,
  input wire logic [TAC_CNT_W-1:0] holdCycles,
  output logic filtOut
);

  tac_dg_state_t s_q;
  tac_dg_state_t s_d;

  // A low input drops the output at once; a high one must persist.
  always_comb
  begin
    s_d = s_q;
    if (!rawIn)
    begin
      s_d.cnt = '0;
      s_d.filt = 1'b0;
    end
    else if (!s_q.filt)
    begin
      if (s_q.cnt + 1'b1 >= holdCycles)
        s_d.filt = 1'b1;
      else
        s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign filtOut = s_q.filt;

endmodule : tac_deglitch
`default_nettype wire

// >>> src/tac_pkg.sv
// Package with register map, reset values, timing constants and types.
`default_nettype none
package tac_pkg;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [7:0] TAC_OFS_OPT_TWO = 8'h38;
  localparam logic [7:0] TAC_OFS_THR_ZERO = 8'h3C;
  localparam logic [15:0] TAC_RST_OPT_TWO = 16'h0080;
  localparam logic [15:0] TAC_RST_THR_ZERO = 16'h4B54;

  // Field positions.
  localparam int TAC_B_EXT_LIM = 7;
  localparam int TAC_B_MON_SEL = 6;
  localparam int TAC_B_CRIT_LSB = 11;
  localparam int TAC_B_CDEG_LSB = 9;
  localparam int TAC_B_OCP = 8;
  localparam int TAC_B_SYSTEM_VOLTAGE_LSB = 6;
  localparam int TAC_B_EXTEND = 5;
  localparam int TAC_B_PW_LSB = 3;
  localparam int TAC_B_HCLR = 2;
  localparam int TAC_B_NDEG = 1;

  // Envelope select bit positions.
  localparam int TAC_E_CMP = 6;
  localparam int TAC_E_CRIT = 5;
  localparam int TAC_E_NOM = 4;
  localparam int TAC_E_DCHG = 3;
  localparam int TAC_E_SYSTEM_VOLTAGE = 2;
  localparam int TAC_E_BATP = 1;
  localparam int TAC_E_ADAPTER_GOOD_SOURCE = 0;
  localparam logic [6:0] TAC_ADAPTER_MASK = 7'h4C;

  // ****************************************************************
  // Thresholds
  // ****************************************************************
  localparam logic [15:0] TAC_CLAMP_MA = 16'h0E00;
  localparam logic [9:0] TAC_CLAMP_PCT = 10'h0E6;
  localparam logic [4:0] TAC_CRIT_OOR = 5'h1F;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int TAC_CLK_MHZ = 40;
  localparam int TAC_CNT_W = 22;
  localparam int TAC_T_CDEG0_NS = 10000;
  localparam int TAC_T_CDEG1_NS = 100000;
  localparam int TAC_T_CDEG2_NS = 400000;
  localparam int TAC_T_CDEG3_NS = 800000;
  localparam int TAC_T_SYSTEM_VOLTAGE_NS = 20000;
  localparam int TAC_T_NDEG0_NS = 1000000;
  localparam int TAC_T_NDEG1_NS = 50000000;
  localparam int TAC_T_PW0_NS = 100000;
  localparam int TAC_T_PW1_NS = 1000000;
  localparam int TAC_T_PW2_NS = 12000000;
  localparam int TAC_T_PW3_NS = 6000000;

  // Least times round up, longest times round down.
  localparam int TAC_CDEG0_CYC = (TAC_T_CDEG0_NS * TAC_CLK_MHZ + 999) / 1000;
  localparam int TAC_CDEG1_CYC = (TAC_T_CDEG1_NS * TAC_CLK_MHZ + 999) / 1000;
  localparam int TAC_CDEG2_CYC = (TAC_T_CDEG2_NS * TAC_CLK_MHZ + 999) / 1000;
  localparam int TAC_CDEG3_CYC = (TAC_T_CDEG3_NS * TAC_CLK_MHZ + 999) / 1000;
  localparam int TAC_SYSTEM_VOLTAGE_CYC = (TAC_T_SYSTEM_VOLTAGE_NS * TAC_CLK_MHZ + 999) / 1000;
  localparam int TAC_NDEG0_CYC = (TAC_T_NDEG0_NS / 1000) * TAC_CLK_MHZ;
  localparam int TAC_NDEG1_CYC = (TAC_T_NDEG1_NS / 1000) * TAC_CLK_MHZ;
  localparam int TAC_PW0_CYC = (TAC_T_PW0_NS * TAC_CLK_MHZ + 999) / 1000;
  localparam int TAC_PW1_CYC = (TAC_T_PW1_NS / 1000) * TAC_CLK_MHZ;
  localparam int TAC_PW2_CYC = (TAC_T_PW2_NS / 1000) * TAC_CLK_MHZ;
  localparam int TAC_PW3_CYC = (TAC_T_PW3_NS / 1000) * TAC_CLK_MHZ;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {TAC_IDLE, TAC_PULSE, TAC_EXTEND} tac_alert_t;

  typedef struct packed {
    logic regWrite;
    logic regRead;
    logic [7:0] regAddr;
    logic [15:0] regWdata;
  } tac_req_t;

  typedef struct packed {
    logic cmpTrig;
    logic dischargeTrig;
    logic batteryPresentTrig;
    logic adapterGoodTrig;
  } tac_ext_src_t;

  typedef struct packed {
    logic [TAC_CNT_W-1:0] cnt;
    logic filt;
  } tac_dg_state_t;

  typedef struct packed {
    logic [15:0] optTwo;
    logic [15:0] thrZero;
    logic [15:0] rdata;
    logic ack;
    tac_alert_t alert;
    logic [TAC_CNT_W-1:0] pulseCnt;
    logic alertN;
    logic [15:0] effLimit;
    logic ocpTrip;
  } tac_state_t;

endpackage : tac_pkg
`default_nettype wire

// >>> src/tac_throttle_alert_config.sv
// Throttle alert configuration registers, comparators and alert pin timing.
// Notes on behaviour
// - With the external-limit bit clear the limit is the register value, set uses the lower of pin and register, reset value set.
// - The monitor select bit reports discharge when 0 (reset) and charge when 1.
// - The critical comparator trips when input current exceeds a percentage of the limit set by bits 15 to 11.
// - Critical codes 0 and 1 mean 110 percent, then 5 percent steps to 230, then 250 to 450, all ones is out of range, default 150.
// - A limit above 3.584 A clamps the critical threshold to 230 percent.
// - Critical deglitch is 10, 100 (default), 400 or 800 microseconds.
// - The overcurrent threshold is 125 or 200 (default) percent of the critical threshold.
// - The system voltage comparator trips below the bits 7 to 6 threshold after a fixed 20 microsecond deglitch.
// - System voltage thresholds are 5.75, 6, 6.25, 6.5 V multi-cell or 2.85, 3.1, 3.35, 3.6 V single-cell, default code 01.
// - With extension set the alert stays low until host clear, otherwise the width field sets the pulse.
// - A non-extended pulse lasts at least 100 us, 1 ms, 12 ms or 6 ms by bits 4 to 3, default 12 ms.
// - Writing 0 to host clear ends an extended alert and releases the pin if no enabled source is active; 1 is idle and the reset value.
// - The nominal comparator trips 10 percent above the limit with 1 ms or 50 ms deglitch.
// - Each source drives the alert only while its envelope bit is set; all clear disables the alert.
// - Without adapter the critical, nominal, battery-present and adapter-good sources are disabled.
`timescale 1ns/1ps
`default_nettype none
module tac_throttle_alert_config
  import tac_pkg::*;
#(
  parameter int CDEG2_CYC = TAC_CDEG2_CYC,
  // The 800 us setting is exactly twice the 400 us one.
  parameter int CDEG3_CYC = 2 * CDEG2_CYC,
  parameter int NDEG0_CYC = TAC_NDEG0_CYC,
  parameter int NDEG1_CYC = TAC_NDEG1_CYC,
  parameter int PW1_CYC = TAC_PW1_CYC,
  parameter int PW2_CYC = TAC_PW2_CYC,
  // The 6 ms width is exactly half the 12 ms one.
  parameter int PW3_CYC = PW2_CYC / 2
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host register command port
  input wire tac_req_t req,
  output logic regAck,
  output logic [15:0] regRdata,
  // Analogue measurements in mA and mV
  input wire logic [15:0] inputCurrentMa,
  input wire logic [15:0] inputLimitSettingMa,
  input wire logic [15:0] externalLimitPinMa,
  input wire logic [15:0] systemVoltageMv,
  input wire logic singleCell,
  // Alert sources outside this block
  input wire logic adapterPresent,
  input wire logic [6:0] envelopeSelect,
  input wire tac_ext_src_t extSrc,
  // Results
  output logic [15:0] effectiveLimitMa,
  output logic batteryMonitorCharge,
  output logic overcurrentTrip,
  output logic throttleAlertN
);

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function automatic logic [9:0] critPct(input logic [4:0] code);
    logic [9:0] c;
    c = {5'h00, code};
    if (code <= 5'h01)
      critPct = 10'h06E;
    else if (code <= 5'h19)
      critPct = 10'h069 + c * 10'h005;
    else
      critPct = 10'h0FA + (c - 10'h01A) * 10'h032;
  endfunction : critPct

  function automatic logic [15:0] vsysMv(input logic [1:0] code,
                                         input logic oneCell);
    vsysMv = oneCell ? 16'h0B22 + {14'h0000, code} * 16'h00FA
                     : 16'h1676 + {14'h0000, code} * 16'h00FA;
  endfunction : vsysMv

  function automatic logic [TAC_CNT_W-1:0] cyc(input int n);
    cyc = TAC_CNT_W'(n);
  endfunction : cyc

  tac_state_t s_q;
  tac_state_t s_d;

  // ****************************************************************
  // Comparators
  // ****************************************************************
  logic [4:0] critCode;
  logic [9:0] pctEff;
  logic [39:0] curX100;
  logic [39:0] critLevel;
  logic critRaw;
  logic nomRaw;
  logic vsysRaw;
  logic ocpRaw;
  logic [TAC_CNT_W-1:0] critHold;
  logic [TAC_CNT_W-1:0] nomHold;
  logic critTrig;
  logic nomTrig;
  logic vsysTrig;

  assign critCode = s_q.thrZero[TAC_B_CRIT_LSB +: 5];
  assign curX100 = 40'(inputCurrentMa) * 40'h64;
  assign pctEff = (inputLimitSettingMa > TAC_CLAMP_MA) ? TAC_CLAMP_PCT
                                                        : critPct(critCode);
  assign critLevel = 40'(inputLimitSettingMa) * 40'(pctEff);
  assign critRaw = (critCode != TAC_CRIT_OOR || inputLimitSettingMa >
                    TAC_CLAMP_MA) && (curX100 > critLevel);
  assign nomRaw = 40'(inputCurrentMa) * 40'h0A >
                  40'(inputLimitSettingMa) * 40'h0B;
  assign vsysRaw = systemVoltageMv <
                   vsysMv(s_q.thrZero[TAC_B_SYSTEM_VOLTAGE_LSB +: 2], singleCell);
  assign ocpRaw = s_q.thrZero[TAC_B_OCP] ? curX100 > critLevel * 40'h2
                  : curX100 * 40'h4 > critLevel * 40'h5;

  always_comb
  begin
    case (s_q.thrZero[TAC_B_CDEG_LSB +: 2])
      2'b00: critHold = cyc(TAC_CDEG0_CYC);
      2'b01: critHold = cyc(TAC_CDEG1_CYC);
      2'b10: critHold = cyc(CDEG2_CYC);
      default: critHold = cyc(CDEG3_CYC);
    endcase
    nomHold = s_q.thrZero[TAC_B_NDEG] ? cyc(NDEG1_CYC) : cyc(NDEG0_CYC);
  end

  tac_deglitch u_critDg (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .rawIn(critRaw),
    .holdCycles(critHold),
    .filtOut(critTrig)
  );

  tac_deglitch u_nomDg (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .rawIn(nomRaw),
    .holdCycles(nomHold),
    .filtOut(nomTrig)
  );

  tac_deglitch u_vsysDg (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .rawIn(vsysRaw),
    .holdCycles(cyc(TAC_SYSTEM_VOLTAGE_CYC)),
    .filtOut(vsysTrig)
  );

  // ****************************************************************
  // Source gating
  // ****************************************************************
  logic [6:0] srcVec;
  logic [6:0] envEff;
  logic anySrc;
  logic [TAC_CNT_W-1:0] pulseHold;
  logic hostClearWr;
  logic wrOptTwo;
  logic wrThrZero;

  assign srcVec = {extSrc.cmpTrig, critTrig, nomTrig, extSrc.dischargeTrig,
                   vsysTrig, extSrc.batteryPresentTrig,
                   extSrc.adapterGoodTrig};
  assign envEff = adapterPresent ? envelopeSelect
                                 : envelopeSelect & TAC_ADAPTER_MASK;
  assign anySrc = |(srcVec & envEff);
  assign wrOptTwo = req.regWrite && req.regAddr == TAC_OFS_OPT_TWO;
  assign wrThrZero = req.regWrite && req.regAddr == TAC_OFS_THR_ZERO;
  assign hostClearWr = wrThrZero && !req.regWdata[TAC_B_HCLR];

  always_comb
  begin
    case (s_q.thrZero[TAC_B_PW_LSB +: 2])
      2'b00: pulseHold = cyc(TAC_PW0_CYC);
      2'b01: pulseHold = cyc(PW1_CYC);
      2'b10: pulseHold = cyc(PW2_CYC);
      default: pulseHold = cyc(PW3_CYC);
    endcase
  end

  // ****************************************************************
  // Registers and alert sequencing
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.ack = req.regWrite || req.regRead;
    if (wrOptTwo)
      s_d.optTwo = req.regWdata & TAC_RST_OPT_TWO
                   | (req.regWdata & 16'h0040);
    if (wrThrZero)
      // Host clear is a strobe: the stored bit always returns to idle.
      s_d.thrZero = {req.regWdata[15:3], 1'b1, req.regWdata[1], 1'b0};
    if (req.regRead)
    begin
      if (req.regAddr == TAC_OFS_OPT_TWO)
        s_d.rdata = s_q.optTwo & 16'h00C0;
      else if (req.regAddr == TAC_OFS_THR_ZERO)
        s_d.rdata = s_q.thrZero;
      else
        s_d.rdata = 16'h0000;
    end
    if (s_q.optTwo[TAC_B_EXT_LIM] && externalLimitPinMa < inputLimitSettingMa)
      s_d.effLimit = externalLimitPinMa;
    else
      s_d.effLimit = inputLimitSettingMa;
    s_d.ocpTrip = ocpRaw;
    case (s_q.alert)
      TAC_IDLE:
      begin
        s_d.pulseCnt = '0;
        if (anySrc)
        begin
          s_d.alertN = 1'b0;
          s_d.alert = s_q.thrZero[TAC_B_EXTEND] ? TAC_EXTEND : TAC_PULSE;
        end
      end
      TAC_PULSE:
      begin
        if (s_q.pulseCnt + 1'b1 < pulseHold)
          s_d.pulseCnt = s_q.pulseCnt + 1'b1;
        else if (!anySrc)
        begin
          s_d.alertN = 1'b1;
          s_d.alert = TAC_IDLE;
        end
      end
      TAC_EXTEND:
      begin
        // a source still active wins over the host clear.
        if (hostClearWr && !anySrc)
        begin
          s_d.alertN = 1'b1;
          s_d.alert = TAC_IDLE;
        end
      end
      default:
      begin
        s_d.alertN = 1'b1;
        s_d.alert = TAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.optTwo <= TAC_RST_OPT_TWO;
      s_q.thrZero <= TAC_RST_THR_ZERO;
      s_q.alertN <= 1'b1;
      s_q.alert <= TAC_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign regAck = s_q.ack;
  assign regRdata = s_q.rdata;
  assign effectiveLimitMa = s_q.effLimit;
  assign batteryMonitorCharge = s_q.optTwo[TAC_B_MON_SEL];
  assign overcurrentTrip = s_q.ocpTrip;
  assign throttleAlertN = s_q.alertN;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_limit_sel;
    !s_q.optTwo[TAC_B_EXT_LIM] ##1 $stable(inputLimitSettingMa)
      |-> effectiveLimitMa == inputLimitSettingMa;
  endproperty
  a_limit_sel: assert property (p_limit_sel) else $error("limit source wrong");

  property p_mon_sel;
    wrOptTwo |=> batteryMonitorCharge == $past(req.regWdata[TAC_B_MON_SEL]);
  endproperty
  a_mon_sel: assert property (p_mon_sel) else $error("monitor select wrong");

  property p_reserved;
    req.regRead && req.regAddr == TAC_OFS_OPT_TWO
      |=> regAck && regRdata[15:8] == 8'h00 && regRdata[5:0] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_clamp;
    inputLimitSettingMa > TAC_CLAMP_MA |-> pctEff == 10'h0E6;
  endproperty
  a_clamp: assert property (p_clamp) else $error("critical clamp missing");

  property p_crit_code;
    inputLimitSettingMa <= TAC_CLAMP_MA && critCode == 5'h09
      |-> pctEff == 10'h096;
  endproperty
  a_crit_code: assert property (p_crit_code) else $error("critical code");

  sequence s_fall;
    $fell(throttleAlertN) && s_q.alert == TAC_PULSE;
  endsequence

  property p_pulse_min;
    s_fall and (pulseHold == cyc(TAC_PW0_CYC)) |-> !throttleAlertN [*8];
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");

  property p_extend_hold;
    s_q.alert == TAC_EXTEND && !hostClearWr |=> !throttleAlertN;
  endproperty
  a_extend_hold: assert property (p_extend_hold) else $error("alert released");

  property p_host_clear;
    s_q.alert == TAC_EXTEND && hostClearWr && !anySrc
      |=> throttleAlertN && s_q.thrZero[TAC_B_HCLR];
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("clear ignored");

  property p_envelope_off;
    envelopeSelect == 7'h00 && throttleAlertN |=> throttleAlertN;
  endproperty
  a_envelope_off: assert property (p_envelope_off) else $error("alert w/o src");

  property p_no_adapter;
    !adapterPresent && (srcVec & TAC_ADAPTER_MASK) == 7'h00 && throttleAlertN
      |=> throttleAlertN;
  endproperty
  a_no_adapter: assert property (p_no_adapter) else $error("src not gated");

  property p_assert_fast;
    throttleAlertN && anySrc |=> !throttleAlertN;
  endproperty
  a_assert_fast: assert property (p_assert_fast) else $error("alert late");

endmodule : tac_throttle_alert_config
`default_nettype wire
